// file: design/reset_cause_pkg.sv
// constants, offsets and field layout of the reset-cause flag block
`default_nettype none
package reset_cause_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CAUSE_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h08;
  localparam logic [7:0] OFF_LAST_EVENT   = 8'h0C;
  localparam logic [7:0] OFF_EVENT_COUNT  = 8'h10;

  // ****************************************
  // field positions, shared by flags, events and interrupts
  // ****************************************
  localparam int unsigned NUM_SRC         = 4;
  localparam int unsigned BIT_BROWN_OUT   = 0;
  localparam int unsigned BIT_POWER_ON    = 1;
  localparam int unsigned BIT_RESET_INSTR = 2;
  localparam int unsigned BIT_PIN_RESET   = 3;

  // ****************************************
  // values after reset, and the default counter width
  // ****************************************
  localparam logic [3:0]  FLAGS_RESET     = 4'hF;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
  localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;
  localparam int unsigned CNT_W_DEFAULT   = 8;

  // wishbone slave phases
  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } wb_state_t;
endpackage
`default_nettype wire

// file: design/reg_access_if.sv
// register access strobes passed from the bus port to the register owners
`default_nettype none
interface reg_access_if;
  logic        wr_stb;  // one-cycle write commit
  logic [7:0]  addr;
  logic [3:0]  sel;
  logic [31:0] wdata;
  logic [31:0] rdata;   // read mux of the top

  modport bus  (output wr_stb, output addr, output sel, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input sel, input wdata);
  modport top  (input wr_stb, input addr, input sel, input wdata, output rdata);
endinterface
`default_nettype wire

// file: design/wb_reg_port.sv
// classic wishbone slave turning bus cycles into register strobes
`default_nettype none
module wb_reg_port (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // register side
  reg_access_if.bus        ra
);
  reset_cause_pkg::wb_state_t state_reg;
  reset_cause_pkg::wb_state_t state_next;
  logic                       req;

  // request is seen only in idle, so a held request is not taken twice
  assign req = cyc_i & stb_i & (state_reg == reset_cause_pkg::WB_IDLE);

  // ****************************************
  // strobes toward the registers
  // ****************************************
  assign ra.wr_stb = req & we_i;
  assign ra.addr   = adr_i;
  assign ra.sel    = sel_i;
  assign ra.wdata  = dat_i;
  assign ack_o     = (state_reg == reset_cause_pkg::WB_ACK);

  // one ack per request, dropped the cycle after
  always_comb begin
    case (state_reg)
      reset_cause_pkg::WB_IDLE: state_next = req ? reset_cause_pkg::WB_ACK
                                                 : reset_cause_pkg::WB_IDLE;
      reset_cause_pkg::WB_ACK:  state_next = reset_cause_pkg::WB_IDLE;
      default:                  state_next = reset_cause_pkg::WB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= reset_cause_pkg::WB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data captured with the request, held until the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= reset_cause_pkg::DATA_ZERO;
    end else if (req) begin
      dat_o <= we_i ? reset_cause_pkg::DATA_ZERO : ra.rdata;
    end
  end
endmodule
`default_nettype wire

// file: design/event_irq.sv
// sticky event status, mask and level interrupt
`default_nettype none
module event_irq #(
  parameter int unsigned N = reset_cause_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // events and register access
  input  wire logic [N-1:0] evt_i,
  reg_access_if.regs        ra,
  // state out
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);
  logic         lane0;
  logic [N-1:0] clr;
  logic [N-1:0] mask_next;

  assign lane0 = ra.wr_stb & ra.sel[0];
  // write one to clear
  assign clr   = (lane0 && ra.addr == reset_cause_pkg::OFF_IRQ_STATUS) ?
                 ra.wdata[N-1:0] : '0;
  // mask after this edge, so the line follows a mask write without a lag
  assign mask_next = (lane0 && ra.addr == reset_cause_pkg::OFF_IRQ_MASK) ?
                     ra.wdata[N-1:0] : mask_o;

  // a new event outranks a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= evt_i | (status_o & ~clr);
    end
  end

  // mask, same layout as status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= reset_cause_pkg::IRQ_MASK_RESET[N-1:0];
    end else begin
      mask_o <= mask_next;
    end
  end

  // level output, registered so it is glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((evt_i | (status_o & ~clr)) & mask_next);
    end
  end
endmodule
`default_nettype wire

// file: design/reset_cause_flags.sv
// reset-cause flag register with wishbone access, event counters and interrupt
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`default_nettype none
module reset_cause_flags #(
  parameter int unsigned CNT_W = reset_cause_pkg::CNT_W_DEFAULT
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // reset-source event pulses from the reset generator
  input  wire logic        pin_reset_evt_i,
  input  wire logic        reset_instr_evt_i,
  input  wire logic        power_on_evt_i,
  input  wire logic        brown_out_evt_i,
  // state toward the core
  output logic      [3:0]  flags_o,
  output logic             irq_o
);
  localparam int unsigned N = reset_cause_pkg::NUM_SRC;

  reg_access_if ra ();

  logic [N-1:0]       evt;
  logic [N-1:0]       flag_clr;
  logic [N-1:0]       flag_set;
  logic [N-1:0]       flags_reg;
  logic [N-1:0]       last_event_reg;
  logic [N-1:0]       irq_status;
  logic [N-1:0]       irq_mask;
  logic [N*CNT_W-1:0] count_reg;
  logic               lane0;
  logic [31:0]        rdata_next;

  // ****************************************
  // bus port and interrupt
  // ****************************************
  wb_reg_port u_port (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .adr_i (adr_i),
    .sel_i (sel_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o),
    .ra    (ra.bus)
  );

  event_irq #(.N(N)) u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    (evt),
    .ra       (ra.regs),
    .status_o (irq_status),
    .mask_o   (irq_mask),
    .irq_o    (irq_o)
  );

  // ****************************************
  // event decode
  // ****************************************
  // events gathered in flag-bit order
  always_comb begin
    evt                                   = '0;
    evt[reset_cause_pkg::BIT_PIN_RESET]   = pin_reset_evt_i;
    evt[reset_cause_pkg::BIT_RESET_INSTR] = reset_instr_evt_i;
    evt[reset_cause_pkg::BIT_POWER_ON]    = power_on_evt_i;
    evt[reset_cause_pkg::BIT_BROWN_OUT]   = brown_out_evt_i;
  end

  // each source clears only its own flags; power-on also clears brown-out
  always_comb begin
    flag_clr                                   = '0;
    flag_clr[reset_cause_pkg::BIT_PIN_RESET]   = pin_reset_evt_i;
    flag_clr[reset_cause_pkg::BIT_RESET_INSTR] = reset_instr_evt_i;
    flag_clr[reset_cause_pkg::BIT_POWER_ON]    = power_on_evt_i;
    flag_clr[reset_cause_pkg::BIT_BROWN_OUT]   = brown_out_evt_i | power_on_evt_i;
  end

  // ****************************************
  // flag register
  // ****************************************
  assign lane0    = ra.wr_stb & ra.sel[0];
  // firmware writes ones to re-arm; a zero written leaves a flag alone
  assign flag_set = (lane0 && ra.addr == reset_cause_pkg::OFF_CAUSE_STATUS) ?
                    ra.wdata[N-1:0] : '0;

  // clear by event wins over a firmware set; unrelated events hold the bit
  generate
    for (genvar i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flags_reg[i] <= reset_cause_pkg::FLAGS_RESET[i];
        end else if (flag_clr[i]) begin
          flags_reg[i] <= 1'b0;
        end else if (flag_set[i]) begin
          flags_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  assign flags_o = flags_reg;

  // ****************************************
  // diagnostics: last events and counters
  // ****************************************
  // last non-empty event vector, kept until the next event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_event_reg <= '0;
    end else if (|evt) begin
      last_event_reg <= evt;
    end
  end

  // saturating count per source; a byte-lane write zeroes that counter,
  // an event in the same cycle still counts as one
  generate
    for (genvar i = 0; i < N; i++) begin : g_cnt
      logic cnt_clr;
      logic cnt_full;
      assign cnt_clr  = ra.wr_stb & ra.sel[i] &
                        (ra.addr == reset_cause_pkg::OFF_EVENT_COUNT);
      assign cnt_full = &count_reg[i*CNT_W +: CNT_W];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          count_reg[i*CNT_W +: CNT_W] <= '0;
        end else if (cnt_clr) begin
          count_reg[i*CNT_W +: CNT_W] <= {{(CNT_W-1){1'b0}}, evt[i]};
        end else if (evt[i] && !cnt_full) begin
          count_reg[i*CNT_W +: CNT_W] <= count_reg[i*CNT_W +: CNT_W] + 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // read mux
  // ****************************************
  // unmapped offsets and unused bits read zero
  always_comb begin
    rdata_next = reset_cause_pkg::DATA_ZERO;
    case (ra.addr)
      reset_cause_pkg::OFF_CAUSE_STATUS: rdata_next[N-1:0] = flags_reg;
      reset_cause_pkg::OFF_IRQ_STATUS:   rdata_next[N-1:0] = irq_status;
      reset_cause_pkg::OFF_IRQ_MASK:     rdata_next[N-1:0] = irq_mask;
      reset_cause_pkg::OFF_LAST_EVENT:   rdata_next[N-1:0] = last_event_reg;
      reset_cause_pkg::OFF_EVENT_COUNT:  rdata_next = 32'(count_reg);
      default:                           rdata_next = reset_cause_pkg::DATA_ZERO;
    endcase
  end

  assign ra.rdata = rdata_next;
endmodule
`default_nettype wire

// file: tb/reset_cause_flags_properties.sv
// concurrent checks on the ports of the reset-cause flag block
`default_nettype none
module reset_cause_flags_properties #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        pin_reset_evt_i,
  input wire logic        reset_instr_evt_i,
  input wire logic        power_on_evt_i,
  input wire logic        brown_out_evt_i,
  input wire logic [3:0]  flags_o,
  input wire logic        irq_o
);
  // ****************************************
  // helpers and properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a flag write is taken only while the slave is idle
  logic flag_wr;
  logic any_evt;
  assign flag_wr = cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00;
  assign any_evt = pin_reset_evt_i || reset_instr_evt_i || power_on_evt_i || brown_out_evt_i;

  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_timing_a: assert property ($rose(cyc_i && stb_i) |=> ack_o) else $error("ack late");
  pin_clear_a: assert property (pin_reset_evt_i |=> !flags_o[3]) else $error("pin flag set");
  instr_clear_a: assert property (reset_instr_evt_i |=> !flags_o[2])
    else $error("instr flag set");
  power_clear_a: assert property (power_on_evt_i |=> flags_o[1:0] == 2'h0)
    else $error("power-on left flags set");
  brown_clear_a: assert property (brown_out_evt_i |=> !flags_o[0])
    else $error("brown-out flag set");
  flag_hold_a: assert property (!any_evt && !flag_wr |=> $stable(flags_o))
    else $error("flags moved without cause");
  write_set_a: assert property (|(flags_o & ~$past(flags_o)) |-> $past(flag_wr))
    else $error("flag rose without write");
  other_hold_a: assert property (brown_out_evt_i && !power_on_evt_i && !flag_wr
    && !pin_reset_evt_i && !reset_instr_evt_i
    |=> flags_o[3:1] == $past(flags_o[3:1])) else $error("brown-out touched other flags");

  cover property (power_on_evt_i ##1 irq_o);
  cover property (pin_reset_evt_i && flag_wr);
  cover property (flag_wr ##1 ack_o);
endmodule

bind reset_cause_flags reset_cause_flags_properties #(.CNT_W(CNT_W)) props (.*);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the reset-cause flag block
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack_o, irq_o;
  logic [7:0]  adr;
  logic [3:0]  sel, evt, flags_o;
  logic [31:0] dat, dat_o, d;
  int          errors = 0;
  int          samples_checked = 0;
  // event bit per source, and the flags each one clears
  logic [3:0]  ev_tab [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [3:0]  clr_tab [4] = '{4'h8, 4'h4, 4'h3, 4'h1};

  always #4 clk_i = ~clk_i;

  reset_cause_flags dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .pin_reset_evt_i(evt[3]), .reset_instr_evt_i(evt[2]),
    .power_on_evt_i(evt[1]), .brown_out_evt_i(evt[0]), .flags_o(flags_o), .irq_o(irq_o));

  // ****************************************
  // bus and event tasks
  // ****************************************
  // one wishbone cycle; ev pulses events at the edge that takes the request
  // the wait has no limit of its own: only the watchdog ends a hung cycle
  task automatic xfer(input int w, input logic [7:0] a, input logic [31:0] v,
                      input int ev, output logic [31:0] q);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat, evt} <= {2'b11, 1'(w), a, 4'h1, v, 4'(ev)};
    @(posedge clk_i);
    evt <= 4'h0;
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic pulse(input logic [3:0] ev);
    @(posedge clk_i);
    evt <= ev;
    @(posedge clk_i);
    evt <= 4'h0;
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {cyc, stb, we, adr, sel, dat, evt} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(0, 8'h00, 0, 0, d); `CHK("flags", 32'h0000_000F, d)
    xfer(0, 8'h08, 0, 0, d); `CHK("mask", 32'h0000_0000, d)
    for (int i = 0; i < 4; i++) begin
      pulse(ev_tab[i]); `CHK("flags_o", ~clr_tab[i], flags_o)
      xfer(1, 8'h00, 32'h0000_0000, 0, d);
      xfer(0, 8'h00, 0, 0, d); `CHK("kept", {28'h0, ~clr_tab[i]}, d)
      xfer(1, 8'h00, 32'h0000_000F, 0, d);
      xfer(0, 8'h00, 0, 0, d); `CHK("set", 32'h0000_000F, d)
    end
    // clearing by an event beats a firmware set in the same cycle
    pulse(4'h8);
    xfer(1, 8'h00, 32'h0000_000F, 8, d);
    xfer(0, 8'h00, 0, 0, d); `CHK("race", 32'h0000_0007, d)
    // interrupt: clear, mask, raise, clear
    xfer(1, 8'h04, 32'h0000_000F, 0, d); `CHK("irq clr", 1'b0, irq_o)
    xfer(1, 8'h08, 32'h0000_0002, 0, d);
    pulse(4'h1); `CHK("irq masked", 1'b0, irq_o)
    pulse(4'h2); `CHK("irq", 1'b1, irq_o)
    xfer(0, 8'h04, 0, 0, d); `CHK("irq status", 32'h0000_0003, d)
    xfer(1, 8'h04, 32'h0000_0002, 0, d); `CHK("irq w1c", 1'b0, irq_o)
    xfer(0, 8'h40, 0, 0, d); `CHK("unmapped", 32'h0000_0000, d)
    xfer(0, 8'h00, 0, 0, d); `CHK("after por", 32'h0000_0004, d)
    // unmasking a pending source raises the line with the mask write itself
    xfer(1, 8'h08, 32'h0000_0001, 0, d); `CHK("irq unmask", 1'b1, irq_o)
    // diagnostics: newest event vector and per-source counts
    xfer(0, 8'h0C, 0, 0, d); `CHK("last event", 32'h0000_0002, d)
    xfer(0, 8'h10, 0, 0, d); `CHK("counts", 32'h0301_0202, d)
    xfer(1, 8'h10, 0, 0, d);
    xfer(0, 8'h10, 0, 0, d); `CHK("count clr", 32'h0301_0200, d)
    give_verdict();
  end
endmodule
`default_nettype wire
